/* File: verilog/mealy_sequencer.sv */
// Fuse-configured Mealy sequencer: S/R registers, preset and output control
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"

// Contract
// - Next registers depend on state and inputs.
// - Forty-eight programmable AND product terms.
// - Twelve set/reset sum-term pairs from products.
// - Pairs drive 8-bit state, 4-bit output.
// - State bits feed back into AND array.
// - Two low state bits also drive pins.
// - Complemented C sum term feeds AND array.
// - S/R flip-flops update on rising clock.
// - Power-up forces all register bits high.
// - Shared pin defaults to asynchronous preset.
// - Blown fuse: pin becomes active-low enable.
// - Blown AND link reads as high.
// - Blown OR link reads as low.
// - First rising edge after preset updates.
// - Preset active inhibits clocking entirely.
module mealy_sequencer
    import seq_pkg::*;
#(
    parameter int N_PT = `SEQ_N_PTERMS,
    parameter bit PIN_IS_OE = 1'b0,
    parameter logic [N_PT*`SEQ_N_LITS-1:0] AND_TRUE = '0,
    parameter logic [N_PT*`SEQ_N_LITS-1:0] AND_COMP = '0,
    parameter logic [`SEQ_N_SUMS*N_PT-1:0] OR_SEL = '0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [`SEQ_N_EXT-1:0] external_inputs,
    input wire logic preset_oe_pin,
    output logic [`SEQ_N_OUTQ-1:0] q_out,
    output logic [`SEQ_N_EXPORT-1:0] exported_state_bits,
    output logic out_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks on the fuse map

    // A C-term product that uses the C literal would be a combinational loop
    function automatic bit c_loop_free();
        bit ok;
        ok = 1'b1;
        for (int t = 0; t < N_PT; t++) begin
            if (OR_SEL[`SEQ_SUM_CTERM*N_PT + t] &&
                (AND_TRUE[t*`SEQ_N_LITS + `SEQ_LIT_CTERM] ||
                 AND_COMP[t*`SEQ_N_LITS + `SEQ_LIT_CTERM])) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    generate
        if (N_PT < 1 || N_PT > 64) begin : g_bad_pt
            $error("product term count out of range");
        end
        if (!c_loop_free()) begin : g_bad_c
            $error("C term product uses the C literal");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Arrays

    localparam seq_regs_t REGS_RST = '{outq: `SEQ_OUTQ_RST,
                                       state: `SEQ_STATE_RST};
    // Preset mode never tristates; enable mode starts disabled
    localparam logic OE_RST = ~PIN_IS_OE;

    seq_regs_t regs;
    seq_regs_t next_regs;
    seq_sr_t sr_terms;
    logic preset_act;
    logic async_preset;
    logic next_out_oe;

    // Fuse pattern arrives only as parameters
    seq_logic_arrays #(
        .N_PT(N_PT),
        .AND_TRUE(AND_TRUE),
        .AND_COMP(AND_COMP),
        .OR_SEL(OR_SEL)
    ) u_arrays (
        .external_inputs(external_inputs),
        .state_bits(regs.state),
        .sr_terms(sr_terms)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register group: state and output S/R flip-flops

    assign preset_act = !PIN_IS_OE && preset_oe_pin;
    // Power-up and pin preset share one asynchronous set path
    assign async_preset = sys_rst | preset_act;

    always_comb begin
        next_regs = regs;
        for (int i = 0; i < `SEQ_N_REGS; i++) begin
            // Set and reset together hold the bit rather than race
            if (sr_terms.set[i] && !sr_terms.reset[i]) begin
                next_regs[i] = 1'b1;
            end else if (sr_terms.reset[i] && !sr_terms.set[i]) begin
                next_regs[i] = 1'b0;
            end
        end
    end

    // No falling-edge arming: the first rising edge after release counts
    always_ff @(posedge core_clk or posedge async_preset) begin
        if (async_preset) begin
            regs <= REGS_RST;
        end else if (clk_en) begin
            regs <= next_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output enable group

    // One cycle of latency from the pin keeps the enable on a flip-flop
    always_comb begin
        next_out_oe = PIN_IS_OE ? !preset_oe_pin : 1'b1;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_oe <= OE_RST;
        end else if (clk_en) begin
            out_oe <= next_out_oe;
        end
    end

    assign q_out = regs.outq;
    assign exported_state_bits = regs.state[`SEQ_N_EXPORT-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    genvar b;
    generate
        for (b = 0; b < `SEQ_N_REGS; b++) begin : g_sr_chk
            property p_sr_set;
                @(posedge core_clk) disable iff (async_preset)
                (clk_en && sr_terms.set[b] && !sr_terms.reset[b])
                    |=> regs[b];
            endproperty
            a_sr_set: assert property (p_sr_set)
                else $error("set term did not raise bit");

            property p_sr_reset;
                @(posedge core_clk) disable iff (async_preset)
                (clk_en && sr_terms.reset[b] && !sr_terms.set[b])
                    |=> !regs[b];
            endproperty
            a_sr_reset: assert property (p_sr_reset)
                else $error("reset term did not clear bit");

            property p_sr_both;
                @(posedge core_clk) disable iff (async_preset)
                (sr_terms.reset[b] && sr_terms.set[b]) |=> $stable(regs[b]);
            endproperty
            a_sr_both: assert property (p_sr_both)
                else $error("bit moved with both terms active");
        end
    endgenerate

    property p_freeze;
        @(posedge core_clk) disable iff (async_preset)
        !clk_en |=> $stable(regs) && $stable(out_oe);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_preset_high;
        @(posedge core_clk) disable iff (sys_rst)
        preset_act[*2] |-> regs == REGS_RST;
    endproperty
    a_preset_high: assert property (p_preset_high)
        else $error("registers not high under preset");

    property p_preset_now;
        @(posedge core_clk)
        async_preset |-> regs == REGS_RST;
    endproperty
    a_preset_now: assert property (p_preset_now)
        else $error("registers not high during reset or preset");

    property p_resume;
        @(posedge core_clk) disable iff (async_preset)
        ($past(preset_act) && clk_en) |=> regs == $past(next_regs);
    endproperty
    a_resume: assert property (p_resume)
        else $error("first edge after preset not taken");

    property p_oe_follow;
        @(posedge core_clk) disable iff (sys_rst)
        (PIN_IS_OE && clk_en) |=> out_oe == !$past(preset_oe_pin);
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("enable does not follow the pin");

    property p_oe_fixed;
        @(posedge core_clk) disable iff (sys_rst)
        !PIN_IS_OE |-> out_oe ##1 out_oe;
    endproperty
    a_oe_fixed: assert property (p_oe_fixed)
        else $error("outputs disabled in preset mode");

    property p_oe_no_preset;
        @(posedge core_clk) disable iff (sys_rst)
        (PIN_IS_OE && preset_oe_pin && clk_en) |=> regs == $past(next_regs);
    endproperty
    a_oe_no_preset: assert property (p_oe_no_preset)
        else $error("pin preset acted in enable mode");

endmodule

`default_nettype wire

/* File: common/seq_map.svh */
// Constants for the fuse-programmed Mealy sequencer: widths, positions, resets
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

`define SEQ_N_EXT 14
`define SEQ_N_STATE 8
`define SEQ_N_OUTQ 4
`define SEQ_N_EXPORT 2
`define SEQ_N_PTERMS 48
`define SEQ_N_REGS 12

// Literal vector layout into the AND array
`define SEQ_LIT_EXT_LSB 0
`define SEQ_LIT_STATE_LSB 14
`define SEQ_LIT_CTERM 22
`define SEQ_N_LITS 23

// Sum term layout: set term at 2*k, reset term at 2*k+1, then the C term
`define SEQ_SUM_CTERM 24
`define SEQ_N_SUMS 25

`define SEQ_STATE_RST 8'hFF
`define SEQ_OUTQ_RST 4'hF

`endif

/* File: common/seq_pkg.sv */
// Types shared by the sequencer modules
`include "seq_map.svh"

package seq_pkg;

    typedef struct packed {
        logic [`SEQ_N_OUTQ-1:0] outq;
        logic [`SEQ_N_STATE-1:0] state;
    } seq_regs_t;

    typedef struct packed {
        logic [`SEQ_N_REGS-1:0] set;
        logic [`SEQ_N_REGS-1:0] reset;
    } seq_sr_t;

endpackage

/* File: verilog/seq_logic_arrays.sv */
// AND array, OR array and complemented C-term feedback of the sequencer
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"

module seq_logic_arrays
    import seq_pkg::*;
#(
    parameter int N_PT = `SEQ_N_PTERMS,
    parameter logic [N_PT*`SEQ_N_LITS-1:0] AND_TRUE = '0,
    parameter logic [N_PT*`SEQ_N_LITS-1:0] AND_COMP = '0,
    parameter logic [`SEQ_N_SUMS*N_PT-1:0] OR_SEL = '0
) (
    input wire logic [`SEQ_N_EXT-1:0] external_inputs,
    input wire logic [`SEQ_N_STATE-1:0] state_bits,
    output var seq_sr_t sr_terms
);

    logic [`SEQ_N_LITS-1:0] lits_pre;
    logic [`SEQ_N_LITS-1:0] lits;
    logic [N_PT-1:0] prod_pre;
    logic [N_PT-1:0] prod;
    logic c_sum;
    logic [`SEQ_N_REGS-1:0] set_v;
    logic [`SEQ_N_REGS-1:0] rst_v;

    // C literal held high in the first pass; terms feeding C never use it
    assign lits_pre = {1'b1, state_bits, external_inputs};
    assign lits = {~c_sum, state_bits, external_inputs};

    genvar t;
    genvar s;
    generate
        for (t = 0; t < N_PT; t++) begin : g_pterm
            // Blown AND link reads as high, so it never pulls the term low
            assign prod_pre[t] =
                &(~AND_TRUE[t*`SEQ_N_LITS +: `SEQ_N_LITS] | lits_pre) &
                &(~AND_COMP[t*`SEQ_N_LITS +: `SEQ_N_LITS] | ~lits_pre);
            assign prod[t] =
                &(~AND_TRUE[t*`SEQ_N_LITS +: `SEQ_N_LITS] | lits) &
                &(~AND_COMP[t*`SEQ_N_LITS +: `SEQ_N_LITS] | ~lits);
        end
        for (s = 0; s < `SEQ_N_REGS; s++) begin : g_sum
            // Blown OR link reads as low, so it adds nothing to the sum
            assign set_v[s] =
                |(prod & OR_SEL[(2*s)*N_PT +: N_PT]);
            assign rst_v[s] =
                |(prod & OR_SEL[(2*s+1)*N_PT +: N_PT]);
        end
    endgenerate

    // One driver for the whole struct keeps the port a single variable
    assign sr_terms = {set_v, rst_v};

    assign c_sum = |(prod_pre & OR_SEL[`SEQ_SUM_CTERM*N_PT +: N_PT]);

endmodule

`default_nettype wire

/* File: sim/seq_pins_model.sv */
// Surrounding system logic: resolves the sequencer's three-state pins
`timescale 1ns/100ps
`default_nettype none

module seq_pins_model (
    input wire logic core_clk,
    input wire logic [3:0] q_out,
    input wire logic [1:0] exported_state_bits,
    input wire logic out_oe,
    output logic [5:0] pins
);
    logic [5:0] last = 6'h00;

    // Floating pins show the inverse of the last driven value
    always_comb begin
        pins = out_oe ? {exported_state_bits, q_out} : ~last;
    end

    always_ff @(posedge core_clk) begin
        if (out_oe) begin
            last <= {exported_state_bits, q_out};
        end
    end
endmodule

`default_nettype wire

/* File: sim/programmable_mealy_sequencer_test.sv */
// Self-checking bench: preset-mode and enable-mode sequencers
`timescale 1ns/100ps
`default_nettype none
`include "seq_map.svh"

module programmable_mealy_sequencer_test;
    import seq_pkg::*;
    localparam int NP = `SEQ_N_PTERMS;
    localparam int NL = `SEQ_N_LITS;
    typedef logic [NP*NL-1:0] and_t;
    typedef logic [`SEQ_N_SUMS*NP-1:0] or_t;
    typedef struct packed {
        seq_regs_t ra;
        logic oa;
        seq_regs_t rb;
        logic ob;
    } exp_t;

    ////////////////////////////////////////////////////////////////////////
    // Last term left fully blown so it reads constant high
    function automatic and_t make_and(input bit comp);
        and_t f;
        f = '0;
        for (int t = 0; t < NP - 1; t++) begin
            if (comp) begin
                f[t*NL+(t*11+3)%22] = 1'b1;
            end else begin
                f[t*NL+(t*7)%22] = 1'b1;
                f[t*NL+22] = (t % 5 == 0);
            end
        end
        return f;
    endfunction

    function automatic or_t make_or();
        or_t f;
        f = '0;
        for (int t = 0; t < NP - 1; t++) begin
            f[(t%24)*NP+t] = 1'b1;
            f[((t+7)%24)*NP+t] = 1'b1;
        end
        f[22*NP+NP-1] = 1'b1;
        f[24*NP+1 +: 3] = 3'h7;
        return f;
    endfunction

    localparam and_t AT = make_and(1'b0);
    localparam and_t AC = make_and(1'b1);
    localparam or_t OS = make_or();

    // Two passes: C term never uses its own literal, so pass one settles it
    function automatic seq_regs_t ref_next(input logic [13:0] x,
                                           input seq_regs_t r);
        logic [22:0] lit;
        logic [NP-1:0] pr;
        logic [24:0] s;
        seq_regs_t n;
        lit = {1'b1, r.state, x};
        for (int p = 0; p < 2; p++) begin
            for (int t = 0; t < NP; t++) begin
                pr[t] = &(~AT[t*NL +: NL] | lit) & &(~AC[t*NL +: NL] | ~lit);
            end
            for (int k = 0; k < 25; k++) begin
                s[k] = |(OS[k*NP +: NP] & pr);
            end
            lit[22] = ~s[24];
        end
        n = r;
        for (int k = 0; k < 12; k++) begin
            if (s[2*k] && !s[2*k+1]) begin
                n[k] = 1'b1;
            end
            if (s[2*k+1] && !s[2*k]) begin
                n[k] = 1'b0;
            end
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic core_clk, sys_rst, clk_en, pin_a, pin_b, oa, ob;
    logic [13:0] ext;
    logic [3:0] qa, qb;
    logic [1:0] pa, pb;
    logic [5:0] pins_b;
    int errors = 0;
    int total_checks = 0;
    exp_t cur;
    exp_t q[$];

    mealy_sequencer #(.PIN_IS_OE(1'b0), .AND_TRUE(AT), .AND_COMP(AC),
        .OR_SEL(OS)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .external_inputs(ext), .preset_oe_pin(pin_a),
        .q_out(qa), .exported_state_bits(pa), .out_oe(oa));
    mealy_sequencer #(.PIN_IS_OE(1'b1), .AND_TRUE(AT), .AND_COMP(AC),
        .OR_SEL(OS)) i_dut_oe (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .external_inputs(ext), .preset_oe_pin(pin_b),
        .q_out(qb), .exported_state_bits(pb), .out_oe(ob));
    seq_pins_model i_pins (.core_clk(core_clk), .q_out(qb),
        .exported_state_bits(pb), .out_oe(ob), .pins(pins_b));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic step(input logic en, input logic pv, input logic ov,
                        input logic rst);
        @(negedge core_clk);
        ext = 14'($urandom);
        clk_en = en;
        pin_a = pv;
        pin_b = ov;
        sys_rst = rst;
        if (rst) begin
            cur = {12'hFFF, 1'b1, 12'hFFF, 1'b0};
        end else begin
            cur.ra = pv ? 12'hFFF : (en ? ref_next(ext, cur.ra) : cur.ra);
            if (en) begin
                cur.rb = ref_next(ext, cur.rb);
                cur.ob = !ov;
            end
        end
        q.push_back(cur);
        if (rst || pv) begin
            #2;
            check(16'({qa, pa}), 16'h003F);
        end
    endtask

    // Scoreboard: one note per rising edge, compared once outputs settle
    initial begin
        exp_t e;
        forever begin
            @(posedge core_clk);
            #1;
            if (q.size() > 0) begin
                e = q.pop_front();
                check(16'({qa, pa}), 16'({e.ra.outq, e.ra.state[1:0]}));
                check(16'({qb, pb}), 16'({e.rb.outq, e.rb.state[1:0]}));
                check(16'({oa, ob}), 16'({e.oa, e.ob}));
                if (e.ob) begin
                    check(16'(pins_b), 16'({e.rb.state[1:0], e.rb.outq}));
                end
            end
        end
    end

    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b0;
        ext = 14'h0000;
        pin_a = 1'b0;
        pin_b = 1'b0;
        cur = {12'hFFF, 1'b1, 12'hFFF, 1'b0};
        void'($urandom(32'h90E8));
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 400; i++) begin
            step(1'(($urandom % 8) != 0), 1'b0, 1'($urandom % 2), 1'b0);
        end
        $display("test random_run done");
        for (int i = 0; i < 300; i++) begin
            step(1'(($urandom % 4) != 0), 1'(($urandom % 4) == 0),
                 1'($urandom % 2), 1'b0);
        end
        $display("test preset_pulses done");
        for (int i = 0; i < 103; i++) begin
            step(1'b1, 1'b0, 1'($urandom % 2), 1'(i < 3));
        end
        $display("test reset_mid done");
        for (int i = 0; i < 10 && q.size() > 0; i++) begin
            @(posedge core_clk);
        end
        #2;
        if (q.size() > 0) begin
            errors++;
            $display("ERROR %0t results missing", $time);
        end
        final_report();
    end
endmodule

`default_nettype wire
